// ===== logic/dxt_exc_seq.sv
// Derived-exception classification, escalation and tail-chain sequencer
// Summary of operation
// - Stack write protection fault on entry is the stacking class protection fault.
// - Stack write bus error on entry is the stacking class bus fault.
// - Entry watchpoint without halting debug raises a debug monitor fault.
// - Vector fetch bus error of the original exception is always hard fault.
// - Entry: debug monitor fault at or below preempted priority is dropped.
// - Entry: other derived fault at or below preempted level becomes hard fault.
// - Entry drop or escalate uses only preempted and derived priorities.
// - Late arrival when derived priority beats the original exception; an escalated hard fault always arrives late.
// - Else the original enters and the derived fault pends.
// - Late-arriving derived handler entered active; original stays pending.
// - Priorities compare as group values, smaller value is higher.
// - Return target is higher of top other active and mask boost.
// - Return stack read faults are unstacking classes; watchpoint gives monitor fault.
// - Return: at or below target drops monitor fault, escalates others.
// - Derived fault on return is entered by tail-chaining.
// - Tail-chain skips unstacking and restacking of key context.
// - Pending exception above return target may be taken by tail-chain.
// - Tail-chain needs handler mode and return code bits 27:4 all ones; without them it still runs and flags UNPRED.
// - Tail-chain deactivates the exception named by status bits 8:0.
// - Tail-chain loads link register with base plus the return code.
// - Pending state set here is recorded and readable.
`include "dxt_params.svh"
module dxt_exc_seq #(
  parameter bit LATE_ARRIVAL_EN = 1'b1,
  parameter bit TAIL_CHAIN_EN = 1'b1,
  parameter int NUM_EXC = `DXT_NUM_EXC
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic ENTRY_START,
  input wire dxt_pkg::dxt_num_type OE_NUM,
  input wire dxt_pkg::dxt_pri_type OE_PRI,
  input wire dxt_pkg::dxt_pri_type PE_PRI,
  input wire logic ENTRY_DONE,
  input wire logic STK_MPU_ERR,
  input wire logic STK_BUS_ERR,
  input wire logic ENTRY_WATCH,
  input wire logic HALT_DBG_EN,
  input wire logic VEC_BUS_ERR,
  input wire dxt_pkg::dxt_pri_type MEMFAULT_PRI,
  input wire dxt_pkg::dxt_pri_type BUSERR_PRI,
  input wire dxt_pkg::dxt_pri_type DBGMON_PRI,
  input wire logic RET_START,
  input wire logic [27:0] RET_CODE,
  input wire dxt_pkg::dxt_num_type STATUS_NUM,
  input wire logic HANDLER_MODE,
  input wire dxt_pkg::dxt_pri_type ACTIVE_TOP_PRI,
  input wire dxt_pkg::dxt_pri_type BOOST_PRI,
  input wire logic RET_DONE,
  input wire logic UNSTK_MPU_ERR,
  input wire logic UNSTK_BUS_ERR,
  input wire logic RET_WATCH,
  input wire logic PEND_VALID,
  input wire dxt_pkg::dxt_num_type PEND_NUM,
  input wire dxt_pkg::dxt_pri_type PEND_PRI,
  input wire logic PEND_CLR,
  input wire dxt_pkg::dxt_num_type PEND_CLR_NUM,
  input wire dxt_pkg::dxt_num_type PEND_RD_NUM,
  output logic PEND_RD_BIT,
  output logic BUSY,
  output logic TAKE,
  output dxt_pkg::dxt_num_type TAKE_NUM,
  output logic SET_PEND,
  output dxt_pkg::dxt_num_type SET_PEND_NUM,
  output dxt_pkg::dxt_class_type FAULT_CLASS,
  output logic DERIVED_DROP,
  output logic TAIL_CHAIN,
  output logic DEACT,
  output dxt_pkg::dxt_num_type DEACT_NUM,
  output logic LINK_WE,
  output logic [31:0] LINK_VAL,
  output logic RET_COMPLETE,
  output logic UNPRED
);
  import dxt_pkg::*;

  if (NUM_EXC < 16 || NUM_EXC > `DXT_NUM_EXC) begin : g_chk
    $error("dxt_exc_seq: NUM_EXC out of range");
  end

  // Priority order among simultaneous faults: vector, protection, bus, watchpoint
  function automatic dxt_class_type dxt_cls(input logic vec, input logic mpu,
                                            input logic bus, input logic dbg,
                                            input logic ret);
    dxt_class_type c;
    c = CLS_NONE;
    if (vec) begin
      c = CLS_VECTOR;
    end else if (mpu) begin
      c = ret ? CLS_MPU_UNSTK : CLS_MPU_STK;
    end else if (bus) begin
      c = ret ? CLS_BUS_UNSTK : CLS_BUS_STK;
    end else if (dbg) begin
      c = CLS_DBGMON;
    end
    return c;
  endfunction : dxt_cls

  dxt_state_type state_q, state_d;
  dxt_num_type oe_num_q, stat_num_q;
  dxt_pri_type oe_pri_q, pe_pri_q, tgt_q;
  logic [27:0] code_q;
  logic hmode_q;
  logic f_mpu_q, f_bus_q, f_dbg_q, f_vec_q;
  logic take_q, pend_q, drop_q, tc_q, deact_q, link_we_q, done_q, unpred_q;
  dxt_num_type take_num_q, pend_num_q, deact_num_q;
  dxt_class_type cls_q;
  logic [31:0] link_q;

  wire in_ret = (state_q == ST_RETURN);
  wire ent_fin = (state_q == ST_ENTRY) && ENTRY_DONE;
  wire ret_fin = in_ret && RET_DONE;
  wire start_any = (state_q == ST_IDLE) && (ENTRY_START || RET_START);

  // Fault inputs of the current phase
  wire cur_mpu = in_ret ? UNSTK_MPU_ERR : STK_MPU_ERR;
  wire cur_bus = in_ret ? UNSTK_BUS_ERR : STK_BUS_ERR;
  wire cur_dbg = in_ret ? RET_WATCH : (ENTRY_WATCH && !HALT_DBG_EN);
  wire cur_vec = !in_ret && VEC_BUS_ERR;
  wire acc_mpu = f_mpu_q || cur_mpu;
  wire acc_bus = f_bus_q || cur_bus;
  wire acc_dbg = f_dbg_q || cur_dbg;
  wire acc_vec = f_vec_q || cur_vec;

  dxt_class_type cls;
  assign cls = dxt_cls(acc_vec, acc_mpu, acc_bus, acc_dbg, in_ret);

  wire has_de = (cls != CLS_NONE);
  wire is_dbg = (cls == CLS_DBGMON);
  wire is_mpu = (cls == CLS_MPU_STK) || (cls == CLS_MPU_UNSTK);
  wire is_bus = (cls == CLS_BUS_STK) || (cls == CLS_BUS_UNSTK);
  dxt_num_type de_num;
  dxt_pri_type de_pri, ref_pri, eff_pri, tgt_d;
  dxt_num_type eff_num;
  assign de_num = is_dbg ? `DXT_NUM_DBGMON : is_mpu ? `DXT_NUM_MEMFAULT :
                  is_bus ? `DXT_NUM_BUSERR : `DXT_NUM_HARD;
  assign de_pri = is_dbg ? DBGMON_PRI : is_mpu ? MEMFAULT_PRI :
                  is_bus ? BUSERR_PRI : `DXT_PRI_HARD;

  // Entry weighs against the preempted level, never the original's
  assign ref_pri = in_ret ? tgt_q : pe_pri_q;
  wire at_or_above = (de_pri >= ref_pri);
  wire drop = has_de && is_dbg && at_or_above;
  wire esc = has_de && !is_dbg && at_or_above;
  assign eff_pri = esc ? `DXT_PRI_HARD : de_pri;
  assign eff_num = esc ? `DXT_NUM_HARD : de_num;

  // Entry outcome
  wire beats_oe = (eff_pri < oe_pri_q);
  wire late = has_de && !drop && (esc || (LATE_ARRIVAL_EN && beats_oe));
  wire ent_pend = has_de && !drop;
  dxt_num_type ent_take_num, ent_pend_num;
  assign ent_take_num = late ? eff_num : oe_num_q;
  assign ent_pend_num = late ? oe_num_q : de_num;

  // Return outcome
  assign tgt_d = (ACTIVE_TOP_PRI < BOOST_PRI) ? ACTIVE_TOP_PRI : BOOST_PRI;
  wire tc_de = has_de && !drop;
  wire tc_pend = !has_de && TAIL_CHAIN_EN && PEND_VALID && (PEND_PRI < tgt_q);
  wire tc = tc_de || tc_pend;
  wire code_ok = hmode_q && (&code_q[`DXT_RET_ONES_MSB:`DXT_RET_ONES_LSB]);
  dxt_num_type ret_take_num;
  assign ret_take_num = tc_de ? eff_num : PEND_NUM;

  wire mem_set = ent_fin && ent_pend;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (ENTRY_START) begin
          state_d = ST_ENTRY;
        end else if (RET_START) begin
          state_d = ST_RETURN;
        end
      end
      ST_ENTRY: begin
        if (ENTRY_DONE) begin
          state_d = ST_IDLE;
        end
      end
      ST_RETURN: begin
        if (RET_DONE) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Context captured at the start of a sequence
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      oe_num_q <= '0;
      oe_pri_q <= '0;
      pe_pri_q <= '0;
      tgt_q <= '0;
      code_q <= '0;
      stat_num_q <= '0;
      hmode_q <= 1'b0;
    end else if (start_any) begin
      oe_num_q <= OE_NUM;
      oe_pri_q <= OE_PRI;
      pe_pri_q <= PE_PRI;
      tgt_q <= tgt_d;
      code_q <= RET_CODE;
      stat_num_q <= STATUS_NUM;
      hmode_q <= HANDLER_MODE;
    end
  end

  // Faults seen anywhere in the sequence are held until its end
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      {f_mpu_q, f_bus_q, f_dbg_q, f_vec_q} <= 4'h0;
    end else if (start_any || state_q == ST_IDLE) begin
      {f_mpu_q, f_bus_q, f_dbg_q, f_vec_q} <= 4'h0;
    end else begin
      {f_mpu_q, f_bus_q, f_dbg_q, f_vec_q} <= {acc_mpu, acc_bus, acc_dbg, acc_vec};
    end
  end

  // Decision pulses, one cycle after the sequence ends
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      {take_q, pend_q, drop_q, tc_q, deact_q, link_we_q, done_q, unpred_q} <= 8'h00;
      take_num_q <= '0;
      pend_num_q <= '0;
      deact_num_q <= '0;
      cls_q <= CLS_NONE;
      link_q <= '0;
    end else begin
      take_q <= ent_fin || (ret_fin && tc);
      pend_q <= mem_set;
      drop_q <= (ent_fin || ret_fin) && drop;
      tc_q <= ret_fin && tc;
      deact_q <= ret_fin && tc;
      link_we_q <= ret_fin && tc;
      done_q <= ret_fin && !tc;
      unpred_q <= ret_fin && tc && !code_ok;
      if (ent_fin || ret_fin) begin
        take_num_q <= ent_fin ? ent_take_num : ret_take_num;
        pend_num_q <= ent_pend_num;
        cls_q <= cls;
        deact_num_q <= stat_num_q;
        link_q <= `DXT_LINK_BASE + {4'h0, code_q};
      end
    end
  end

  // Pending bits stay readable for the control/state registers
  dxt_pend_mem #(
    .NUM(NUM_EXC),
    .AW(9)
  ) u_pend (
    .clk(CLK),
    .rst_b(RST_B),
    .set_en(mem_set),
    .set_idx(ent_pend_num),
    .clr_en(PEND_CLR),
    .clr_idx(PEND_CLR_NUM),
    .rd_idx(PEND_RD_NUM),
    .rd_bit(PEND_RD_BIT)
  );

  assign BUSY = (state_q != ST_IDLE);
  assign TAKE = take_q;
  assign TAKE_NUM = take_num_q;
  assign SET_PEND = pend_q;
  assign SET_PEND_NUM = pend_num_q;
  assign FAULT_CLASS = cls_q;
  assign DERIVED_DROP = drop_q;
  assign TAIL_CHAIN = tc_q;
  assign DEACT = deact_q;
  assign DEACT_NUM = deact_num_q;
  assign LINK_WE = link_we_q;
  assign LINK_VAL = link_q;
  assign RET_COMPLETE = done_q;
  assign UNPRED = unpred_q;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  AST_VEC_HARD: assert property (
    ent_fin && acc_vec && !at_or_above |=> TAKE && TAKE_NUM == `DXT_NUM_HARD)
    else $error("vector fetch error not taken as hard fault");
  AST_ENTRY_DROP: assert property (
    ent_fin && is_dbg && (de_pri >= pe_pri_q)
    |=> TAKE && DERIVED_DROP && !SET_PEND && TAKE_NUM == $past(oe_num_q))
    else $error("dropped monitor fault did not take original");
  AST_ENTRY_ESC: assert property (
    ent_fin && has_de && !is_dbg && (de_pri >= pe_pri_q)
    |=> TAKE_NUM == `DXT_NUM_HARD && SET_PEND && SET_PEND_NUM == $past(oe_num_q))
    else $error("entry escalation wrong");
  AST_NO_LATE_LOWER: assert property (
    ent_fin && has_de && (de_pri < pe_pri_q) && (de_pri >= oe_pri_q)
    |=> TAKE_NUM == $past(oe_num_q) && SET_PEND && SET_PEND_NUM == $past(de_num))
    else $error("late arrival by a lower derived fault");
  AST_CLASS_STK: assert property (
    ent_fin && !acc_vec && acc_mpu |=> FAULT_CLASS == CLS_MPU_STK)
    else $error("stacking protection class wrong");
  AST_RET_ESC: assert property (
    ret_fin && has_de && !is_dbg && (de_pri >= tgt_q)
    |=> TAIL_CHAIN && TAKE_NUM == `DXT_NUM_HARD)
    else $error("return escalation wrong");
  AST_RET_DROP: assert property (
    ret_fin && drop |=> RET_COMPLETE && !TAKE && !SET_PEND && !LINK_WE && !DEACT)
    else $error("dropped return fault had side effects");
  AST_TC_DEACT: assert property (
    ret_fin && tc |=> DEACT && DEACT_NUM == $past(stat_num_q) && TAKE)
    else $error("tail-chain deactivation wrong");
  AST_TC_LR: assert property (
    ret_fin && tc |=> LINK_WE && LINK_VAL == `DXT_LINK_BASE + {4'h0, $past(code_q)})
    else $error("tail-chain link value wrong");
  AST_PEND_SEEN: assert property (
    SET_PEND && PEND_RD_NUM == SET_PEND_NUM |=> PEND_RD_BIT)
    else $error("pending bit not recorded");

  COV_ENTRY_LATE: cover property (ent_fin && late && !esc);
  COV_ENTRY_ESC: cover property (ent_fin && esc);
  COV_RET_PEND_TC: cover property (ret_fin && tc_pend);
  COV_RET_DROP: cover property (ret_fin && drop);
endmodule : dxt_exc_seq

// ===== logic/dxt_params.svh
// Constants for the derived-exception and tail-chain sequencer
`ifndef DXT_PARAMS_SVH
`define DXT_PARAMS_SVH
`define DXT_NUM_HARD 9'h003
`define DXT_NUM_MEMFAULT 9'h004
`define DXT_NUM_BUSERR 9'h005
`define DXT_NUM_DBGMON 9'h00c
`define DXT_PRI_HARD 9'sh1ff
`define DXT_LINK_BASE 32'hf000_0000
`define DXT_RET_ONES_MSB 27
`define DXT_RET_ONES_LSB 4
`define DXT_NUM_EXC 512
`endif

// ===== logic/dxt_pkg.sv
// Types for the derived-exception and tail-chain sequencer
package dxt_pkg;
  typedef logic signed [8:0] dxt_pri_type;
  typedef logic [8:0] dxt_num_type;
  typedef enum logic [2:0] {
    CLS_NONE = 3'h0,
    CLS_MPU_STK = 3'h1,
    CLS_BUS_STK = 3'h2,
    CLS_MPU_UNSTK = 3'h3,
    CLS_BUS_UNSTK = 3'h4,
    CLS_DBGMON = 3'h5,
    CLS_VECTOR = 3'h6
  } dxt_class_type;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ENTRY = 2'h1,
    ST_RETURN = 2'h2
  } dxt_state_type;
endpackage : dxt_pkg

// ===== logic/dxt_pend_mem.sv
// Pending-state table, one bit per exception number, registered read
module dxt_pend_mem #(
  parameter int NUM = 512,
  parameter int AW = 9
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic set_en,
  input wire logic [AW-1:0] set_idx,
  input wire logic clr_en,
  input wire logic [AW-1:0] clr_idx,
  input wire logic [AW-1:0] rd_idx,
  output logic rd_bit
);
  logic [NUM-1:0] pend_q;
  logic [NUM-1:0] pend_d;
  logic rd_q;
  wire [NUM-1:0] set_mask = set_en ? (NUM'(1) << set_idx) : '0;
  wire [NUM-1:0] clr_mask = clr_en ? (NUM'(1) << clr_idx) : '0;

  if (NUM > (1 << AW) || NUM < 16) begin : g_chk
    $error("dxt_pend_mem: NUM does not fit AW");
  end

  // Set wins over a clear of the same bit
  assign pend_d = (pend_q & ~clr_mask) | set_mask;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_q <= '0;
      rd_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
      rd_q <= pend_q[rd_idx];
    end
  end

  assign rd_bit = rd_q;
endmodule : dxt_pend_mem

// ===== tb/dxt_mem_model.sv
// Memory-side model: answers stack and vector traffic after a chosen latency
module dxt_mem_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic go,
  input wire logic [3:0] err,
  input wire logic [1:0] lat,
  output logic done,
  output logic [3:0] flt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic act_q;
  logic [1:0] cnt_q;
  logic [3:0] err_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      act_q <= 1'b0;
      cnt_q <= 2'h0;
      err_q <= 4'h0;
    end else if (go) begin
      act_q <= 1'b1;
      cnt_q <= lat;
      err_q <= err;
    end else if (act_q) begin
      act_q <= (cnt_q != 2'h0);
      cnt_q <= cnt_q - 2'h1;
    end
  end
  assign done = act_q && (cnt_q == 2'h0);
  // Error strobes only in the closing beat, so a stale error never leaks
  assign flt = done ? err_q : 4'h0;
endmodule : dxt_mem_model

// ===== tb/derived_exception_tail_chain_tb_top.sv
// Self-checking bench for the derived-exception and tail-chain sequencer
module derived_exception_tail_chain_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dxt_pkg::*;
  typedef struct {
    logic tk, sp, dr, tc, rc, un;
    dxt_num_type tn, sn, dn;
    dxt_class_type cl;
    logic [31:0] lk;
  } dxt_exp_type;
  logic clk = 1'b0, rst_b = 1'b0, entry_start = 1'b0, ret_start = 1'b0, go = 1'b0;
  logic halt_dbg_en = 1'b0, handler_mode = 1'b0, pend_valid = 1'b0, pend_clr = 1'b0;
  logic done, take, set_pend, derived_drop, tail_chain, deact, link_we, ret_complete;
  logic unpred, busy, pend_rd_bit;
  logic [3:0] err = 4'h0, flt;
  logic [1:0] lat = 2'h0;
  logic [27:0] ret_code = 28'h0;
  logic [31:0] link_val;
  dxt_num_type oe_num = 9'h0, status_num = 9'h0, pend_num = 9'h0, pend_clr_num = 9'h0;
  dxt_num_type pend_rd_num = 9'h0, take_num, set_pend_num, deact_num;
  dxt_pri_type oe_pri = 9'sh0, pe_pri = 9'sh0, mem_pri = 9'sh0, bus_pri = 9'sh0;
  dxt_pri_type dbg_pri = 9'sh0, act_pri = 9'sh0, boost_pri = 9'sh0, pend_pri = 9'sh0;
  dxt_class_type fault_class;
  dxt_exp_type q[$];
  dxt_exp_type m;
  int n_fail = 0;
  int checks_done = 0;

  dxt_exc_seq i_dxt_exc_seq (.CLK(clk), .RST_B(rst_b), .ENTRY_START(entry_start),
    .OE_NUM(oe_num), .OE_PRI(oe_pri), .PE_PRI(pe_pri), .ENTRY_DONE(done),
    .STK_MPU_ERR(flt[0]), .STK_BUS_ERR(flt[1]), .ENTRY_WATCH(flt[2]),
    .HALT_DBG_EN(halt_dbg_en), .VEC_BUS_ERR(flt[3]), .MEMFAULT_PRI(mem_pri),
    .BUSERR_PRI(bus_pri), .DBGMON_PRI(dbg_pri), .RET_START(ret_start),
    .RET_CODE(ret_code), .STATUS_NUM(status_num), .HANDLER_MODE(handler_mode),
    .ACTIVE_TOP_PRI(act_pri), .BOOST_PRI(boost_pri), .RET_DONE(done),
    .UNSTK_MPU_ERR(flt[0]), .UNSTK_BUS_ERR(flt[1]), .RET_WATCH(flt[2]),
    .PEND_VALID(pend_valid), .PEND_NUM(pend_num), .PEND_PRI(pend_pri),
    .PEND_CLR(pend_clr), .PEND_CLR_NUM(pend_clr_num), .PEND_RD_NUM(pend_rd_num),
    .PEND_RD_BIT(pend_rd_bit), .BUSY(busy), .TAKE(take), .TAKE_NUM(take_num),
    .SET_PEND(set_pend), .SET_PEND_NUM(set_pend_num), .FAULT_CLASS(fault_class),
    .DERIVED_DROP(derived_drop), .TAIL_CHAIN(tail_chain), .DEACT(deact),
    .DEACT_NUM(deact_num), .LINK_WE(link_we), .LINK_VAL(link_val),
    .RET_COMPLETE(ret_complete), .UNPRED(unpred));

  dxt_mem_model i_dxt_mem_model (.clk(clk), .rst_b(rst_b), .go(go), .err(err),
    .lat(lat), .done(done), .flt(flt));

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic stop_test();
    if (n_fail == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (e !== g) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  function automatic dxt_exp_type exp_entry();
    dxt_exp_type x;
    dxt_num_type dn;
    dxt_pri_type dp;
    x = '{cl: CLS_NONE, default: '0};
    x.tk = 1'b1;
    x.tn = oe_num;
    if (err[3]) begin
      x.cl = CLS_VECTOR;
      dn = 9'h003;
      dp = 9'sh1ff;
    end else if (err[0]) begin
      x.cl = CLS_MPU_STK;
      dn = 9'h004;
      dp = mem_pri;
    end else if (err[1]) begin
      x.cl = CLS_BUS_STK;
      dn = 9'h005;
      dp = bus_pri;
    end else if (err[2] && !halt_dbg_en) begin
      x.cl = CLS_DBGMON;
      dn = 9'h00c;
      dp = dbg_pri;
    end
    if (x.cl == CLS_NONE) return x;
    x.sp = 1'b1;
    x.sn = oe_num;
    // Original priority deliberately absent from the first two tests
    if (dp >= pe_pri && x.cl == CLS_DBGMON) begin
      x.dr = 1'b1;
      x.sp = 1'b0;
    end else if (dp >= pe_pri) begin
      x.tn = 9'h003;
    end else if (dp < oe_pri) begin
      x.tn = dn;
    end else begin
      x.sn = dn;
    end
    return x;
  endfunction : exp_entry

  function automatic dxt_exp_type exp_ret();
    dxt_exp_type x;
    dxt_pri_type tgt;
    dxt_pri_type dp;
    x = '{cl: CLS_NONE, default: '0};
    tgt = (act_pri < boost_pri) ? act_pri : boost_pri;
    x.tn = 9'h003;
    if (err[0]) begin
      x.cl = CLS_MPU_UNSTK;
      dp = mem_pri;
    end else if (err[1]) begin
      x.cl = CLS_BUS_UNSTK;
      dp = bus_pri;
    end else if (err[2]) begin
      x.cl = CLS_DBGMON;
      dp = dbg_pri;
    end
    if (x.cl != CLS_NONE && dp >= tgt && x.cl == CLS_DBGMON) x.dr = 1'b1;
    else if (x.cl != CLS_NONE && dp < tgt) x.tn = err[0] ? 9'h004 : 9'h005;
    else if (x.cl == CLS_NONE && pend_valid && pend_pri < tgt) x.tn = pend_num;
    else if (x.cl == CLS_NONE) x.dr = 1'b0;
    if (x.cl == CLS_DBGMON && dp < tgt) x.tn = 9'h00c;
    x.tc = !x.dr && (x.cl != CLS_NONE || (pend_valid && pend_pri < tgt));
    x.rc = !x.tc;
    x.tk = x.tc;
    x.dn = status_num;
    x.lk = 32'hf000_0000 + {4'h0, ret_code};
    x.un = x.tc && (!handler_mode || !(&ret_code[27:4]));
    return x;
  endfunction : exp_ret

  always @(negedge clk) begin
    if (take === 1'b1 || ret_complete === 1'b1) begin
      if (q.size() == 0) begin
        chk("extra_result", 32'h0, 32'h1);
      end else begin
        m = q.pop_front();
        chk("take", 32'(m.tk), 32'(take));
        if (m.tk) chk("take_num", 32'(m.tn), 32'(take_num));
        chk("set_pend", 32'(m.sp), 32'(set_pend));
        if (m.sp) chk("set_pend_num", 32'(m.sn), 32'(set_pend_num));
        chk("class", 32'(m.cl), 32'(fault_class));
        chk("drop", 32'(m.dr), 32'(derived_drop));
        chk("tail", 32'(m.tc), 32'(tail_chain));
        chk("complete", 32'(m.rc), 32'(ret_complete));
        chk("deact", 32'(m.tc), 32'(deact));
        chk("link_we", 32'(m.tc), 32'(link_we));
        chk("unpred", 32'(m.un), 32'(unpred));
        if (m.tc) chk("deact_num", 32'(m.dn), 32'(deact_num));
        if (m.tc) chk("link_val", m.lk, link_val);
      end
    end
  end

  task automatic pend_chk(dxt_num_type n);
    @(posedge clk);
    pend_rd_num <= n;
    @(posedge clk);
    pend_clr <= 1'b1;
    pend_clr_num <= n;
    @(negedge clk);
    chk("pend_set", 32'h1, 32'(pend_rd_bit));
    @(posedge clk);
    pend_clr <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk("pend_clr", 32'h0, 32'(pend_rd_bit));
  endtask : pend_chk

  task automatic run_op();
    dxt_exp_type x;
    logic r;
    r = 1'($urandom_range(1));
    @(posedge clk);
    err <= 4'(5'h1 << $urandom_range(4)) & (r ? 4'h7 : 4'hf);
    lat <= 2'($urandom);
    oe_num <= 9'($urandom_range(63, 16));
    status_num <= 9'($urandom_range(63, 16));
    pend_num <= 9'($urandom_range(63, 16));
    {oe_pri, pe_pri, mem_pri, bus_pri} <= {9'($urandom_range(7)), 9'($urandom_range(7)),
      9'($urandom_range(7)), 9'($urandom_range(7))};
    {dbg_pri, act_pri, boost_pri, pend_pri} <= {9'($urandom_range(7)),
      9'($urandom_range(7)), 9'($urandom_range(7)), 9'($urandom_range(7))};
    {halt_dbg_en, pend_valid} <= 2'($urandom);
    handler_mode <= ($urandom_range(7) != 0);
    ret_code <= {($urandom_range(3) == 0) ? 24'($urandom) : 24'hff_ffff, 4'($urandom)};
    @(posedge clk);
    x = r ? exp_ret() : exp_entry();
    q.push_back(x);
    entry_start <= !r;
    ret_start <= r;
    go <= 1'b1;
    @(posedge clk);
    // Stray starts while busy must be ignored
    entry_start <= 1'($urandom);
    ret_start <= 1'($urandom);
    go <= 1'b0;
    @(negedge clk);
    chk("busy", 32'h1, 32'(busy));
    @(posedge clk);
    entry_start <= 1'b0;
    ret_start <= 1'b0;
    for (int i = 0; i < 20 && q.size() != 0; i++) @(negedge clk);
    chk("result_seen", 32'h0, 32'(q.size()));
    chk("busy_end", 32'h0, 32'(busy));
    if (!r && x.sp) pend_chk(x.sn);
  endtask : run_op

  initial begin
    void'($urandom(14));
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (400) run_op();
    stop_test();
  end

  initial begin
    repeat (30000) @(posedge clk);
    n_fail++;
    stop_test();
  end
endmodule : derived_exception_tail_chain_tb_top
